// ---- async_tx_defs.svh ----
`ifndef ASYNC_TX_DEFS_SVH
`define ASYNC_TX_DEFS_SVH

// register byte addresses
`define ATX_REQ_CTRL_SET 8'h00
`define ATX_REQ_CTRL_CLR 8'h04
`define ATX_RSP_CTRL_SET 8'h08
`define ATX_RSP_CTRL_CLR 8'h0C
`define ATX_INT_EVENT_SET 8'h10
`define ATX_INT_EVENT_CLR 8'h14
`define ATX_NODE_ID 8'h18
`define ATX_RETRY_CFG 8'h1C

// context control fields
`define ATX_CC_RUN 15
`define ATX_CC_WAKE 12
`define ATX_CC_DEAD 11
`define ATX_CC_ACTIVE 10
`define ATX_CC_SPD_HI 7
`define ATX_CC_SPD_LO 5
`define ATX_CC_EVT_HI 4
`define ATX_CC_EVT_LO 0

// interrupt event bits
`define ATX_IE_REQ_SENT 0
`define ATX_IE_RSP_SENT 1
`define ATX_IE_BUS_RESET 2

// node id fields
`define ATX_BUS_HI 15
`define ATX_BUS_LO 6
`define ATX_NODE_HI 5
`define ATX_NODE_LO 0

// internal header quadlet 0 fields
`define ATX_H0_SRCBUS 23
`define ATX_H0_SPD_HI 18
`define ATX_H0_SPD_LO 16
`define ATX_H0_TL_HI 15
`define ATX_H0_TL_LO 10
`define ATX_H0_RT_HI 9
`define ATX_H0_RT_LO 8
`define ATX_H0_TC_HI 7
`define ATX_H0_TC_LO 4

// codes
`define ATX_LOCAL_BUS 10'h03FF
`define ATX_ACK_COMPLETE 5'h11
`define ATX_ACK_PENDING 5'h12
`define ATX_ACK_BUSY_X 5'h14
`define ATX_ACK_BUSY_A 5'h15
`define ATX_ACK_BUSY_B 5'h16
`define ATX_EVT_MISSING_ACK 5'h03
`define ATX_EVT_FLUSHED 5'h0F
`define ATX_RT_1 2'h0
`define ATX_RT_X 2'h1
`define ATX_RT_A 2'h2
`define ATX_RT_B 2'h3
`define ATX_IRQ_ALWAYS 2'h3
`define ATX_IRQ_ON_ERR 2'h1
`define ATX_TC_QREAD_REQ 4'h4
`define ATX_TC_WRITE_RSP 4'h2
`define ATX_TC_STREAM 4'hA
`define ATX_NODE_UNSET 6'h3F

`endif

// ---- async_tx_pkg.sv ----
package async_tx_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_SEND = 3'b001,
        ST_ACK = 3'b010,
        ST_STATUS = 3'b011
    } tx_state_e;

    // one descriptor's header quadlets as handed over by the fetch logic
    typedef struct packed
    {
        logic valid;
        logic ctx;
        logic [1:0] irqCtl;
        logic [31:0] q0;
        logic [31:0] q1;
        logic [31:0] q2;
        logic [31:0] q3;
    } desc_s;

    typedef struct packed
    {
        logic valid;
        logic [4:0] code;
    } ack_s;

    typedef struct packed
    {
        logic valid;
        logic last;
        logic [2:0] speed;
        logic [31:0] data;
    } pkt_s;

endpackage : async_tx_pkg

// ---- async_transmit_context.sv ----
// Function
// - final command completion writes context control low sixteen bits as status
// - written-back status always carries active as one
// - bus reset stops all further transmit packets from both contexts
// - reset after send but before ack completes with missing-ack code
// - reset while packet unsent may complete it as flushed
// - active clears only when transfers stopped and status writes done
// - discard transmit contents until bus reset event cleared
// - busied packets are resent under the retry configuration
// - dual-phase retry inserts retry_1, retry X, retry_A or retry_B itself
// - sent interrupt on control 11, or 01 with non-success ack
// - no-data, quadlet, block, PHY and stream formats are accepted
// - destination ID goes first quadlet, own source ID second quadlet
// - source bus bits are 3FF or bus number per select bit
// - packet goes at the speed code given in the header
// - rt carried through as given or replaced by a retry code
// - reserved header bits forwarded untouched; the code sends none of the first quadlet's bits 31:16, reserved ones included
// - destination ID is bus number over node number
// - fourth quadlet is write data or block read length
// - tLabel and tCode carried into the sent packet
// - run and wake set by set address, only run cleared by clear address
// - event code field records ack code or error event
`timescale 1ns/1ps
`include "async_tx_defs.svh"

module async_transmit_context #(
    parameter int ADDR_W = 8,
    parameter bit DUAL_PHASE = 1'b1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // descriptor side
    input wire async_tx_pkg::desc_s desc,
    output logic descReady,
    output logic statusValid,
    output logic statusCtx,
    output logic [15:0] statusData,
    input wire logic statusDone,
    // link side
    output async_tx_pkg::pkt_s pkt,
    input wire logic pktReady,
    input wire async_tx_pkg::ack_s ack,
    input wire logic busResetIn
);

    generate
        if (ADDR_W < 5)
        begin : g_chk
            $error("ADDR_W too small for the register map");
        end
    endgenerate

    logic [15:0] ctrl_reg [2];
    logic [2:0] interrupt_event_reg_reg;
    logic [15:0] nodeId_reg;
    logic [3:0] retryCfg_reg;
    async_tx_pkg::tx_state_e state_reg;
    async_tx_pkg::tx_state_e state_next;
    logic [127:0] hdr_reg;
    logic ctx_reg;
    logic [1:0] irq_reg;
    logic [1:0] qIdx_reg;
    logic [1:0] rt_reg;
    logic [3:0] retryCnt_reg;
    logic [4:0] doneCode;
    logic doneNow;
    logic retryNow;
    logic flushing;
    logic take;
    logic [1:0] lastIdx;
    logic [31:0] quad;
    logic [9:0] srcBus;
    logic [7:0] wa;
    logic doneCtx;
    logic [1:0] doneIrq;

    assign wa = 8'(regAddr);
    assign flushing = interrupt_event_reg_reg[`ATX_IE_BUS_RESET];
    assign take = desc.valid && descReady;
    assign doneCtx = take ? desc.ctx : ctx_reg;
    assign doneIrq = take ? desc.irqCtl : irq_reg;
    // no-data formats are three quadlets, quadlet formats four
    assign lastIdx = (hdr_reg[`ATX_H0_TC_HI+96:`ATX_H0_TC_LO+96] == `ATX_TC_QREAD_REQ ||
        hdr_reg[`ATX_H0_TC_HI+96:`ATX_H0_TC_LO+96] == `ATX_TC_WRITE_RSP) ? 2'd2 : 2'd3;
    assign srcBus = hdr_reg[`ATX_H0_SRCBUS+96] ? nodeId_reg[`ATX_BUS_HI:`ATX_BUS_LO]
        : `ATX_LOCAL_BUS;

    // header reorder into wire order
    always_comb
    begin
        case (qIdx_reg)
            2'd0:
            begin
                quad = {hdr_reg[95:80], hdr_reg[111:106], rt_reg, hdr_reg[103:96]};
            end
            2'd1:
            begin
                quad = {srcBus, nodeId_reg[`ATX_NODE_HI:`ATX_NODE_LO], hdr_reg[79:64]};
            end
            2'd2:
            begin
                quad = hdr_reg[63:32];
            end
            default:
            begin
                quad = hdr_reg[31:0];
            end
        endcase
    end

    // completion decision
    always_comb
    begin
        doneNow = 1'b0;
        retryNow = 1'b0;
        doneCode = `ATX_EVT_FLUSHED;
        state_next = state_reg;
        case (state_reg)
            async_tx_pkg::ST_IDLE:
            begin
                if (take)
                begin
                    if (flushing)
                    begin
                        doneNow = 1'b1;
                    end
                    else
                    begin
                        state_next = async_tx_pkg::ST_SEND;
                    end
                end
            end
            async_tx_pkg::ST_SEND:
            begin
                if (flushing)
                begin
                    doneNow = 1'b1;
                end
                else if (pkt.valid && pktReady && pkt.last)
                begin
                    state_next = async_tx_pkg::ST_ACK;
                end
            end
            async_tx_pkg::ST_ACK:
            begin
                if (flushing)
                begin
                    doneNow = 1'b1;
                    doneCode = `ATX_EVT_MISSING_ACK;
                end
                else if (ack.valid)
                begin
                    if ((ack.code == `ATX_ACK_BUSY_X || ack.code == `ATX_ACK_BUSY_A ||
                        ack.code == `ATX_ACK_BUSY_B) && retryCnt_reg < retryCfg_reg)
                    begin
                        retryNow = 1'b1;
                        state_next = async_tx_pkg::ST_SEND;
                    end
                    else
                    begin
                        doneNow = 1'b1;
                        doneCode = ack.code;
                    end
                end
            end
            async_tx_pkg::ST_STATUS:
            begin
                if (statusDone)
                begin
                    state_next = async_tx_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_next = async_tx_pkg::ST_IDLE;
            end
        endcase
        if (doneNow)
        begin
            state_next = async_tx_pkg::ST_STATUS;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= async_tx_pkg::ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // descriptor capture and retry bookkeeping
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hdr_reg <= 128'h0;
            ctx_reg <= 1'b0;
            irq_reg <= 2'b00;
            rt_reg <= `ATX_RT_X;
            retryCnt_reg <= 4'h0;
            qIdx_reg <= 2'd0;
        end
        else
        begin
            if (take)
            begin
                hdr_reg <= {desc.q0, desc.q1, desc.q2, desc.q3};
                ctx_reg <= desc.ctx;
                irq_reg <= desc.irqCtl;
                retryCnt_reg <= 4'h0;
                qIdx_reg <= 2'd0;
                // single phase passes software rt through untouched
                rt_reg <= DUAL_PHASE ? `ATX_RT_1 : desc.q0[`ATX_H0_RT_HI:`ATX_H0_RT_LO];
            end
            else if (retryNow)
            begin
                retryCnt_reg <= retryCnt_reg + 4'h1;
                qIdx_reg <= 2'd0;
                if (DUAL_PHASE)
                begin
                    rt_reg <= (ack.code == `ATX_ACK_BUSY_A) ? `ATX_RT_A :
                        (ack.code == `ATX_ACK_BUSY_B) ? `ATX_RT_B : `ATX_RT_X;
                end
            end
            else if (pkt.valid && pktReady && !pkt.last)
            begin
                qIdx_reg <= qIdx_reg + 2'd1;
            end
        end
    end

    // link output; a bus reset drops the packet at once
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pkt <= '0;
        end
        else if (state_reg == async_tx_pkg::ST_SEND && state_next == state_reg && !busResetIn)
        begin
            if (!(pkt.valid && pktReady))
            begin
                pkt.valid <= 1'b1;
                pkt.data <= quad;
                pkt.speed <= hdr_reg[`ATX_H0_SPD_HI+96:`ATX_H0_SPD_LO+96];
                pkt.last <= qIdx_reg == lastIdx;
            end
            else
            begin
                pkt.valid <= 1'b0;
            end
        end
        else
        begin
            pkt.valid <= 1'b0;
            pkt.last <= 1'b0;
        end
    end

    // status write-back
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            statusValid <= 1'b0;
            statusCtx <= 1'b0;
            statusData <= 16'h0;
            descReady <= 1'b0;
        end
        else
        begin
            descReady <= state_next == async_tx_pkg::ST_IDLE && !take;
            if (doneNow)
            begin
                statusValid <= 1'b1;
                statusCtx <= doneCtx;
                statusData <= {ctrl_reg[doneCtx][15:11], 1'b1,
                    ctrl_reg[doneCtx][9:5], doneCode};
            end
            else if (statusDone)
            begin
                statusValid <= 1'b0;
            end
        end
    end

    // context control, one per context
    for (genvar c = 0; c < 2; c++)
    begin : g_ctx
        logic setHit;
        logic clrHit;
        logic busyHere;
        assign setHit = regWr && wa == (c == 0 ? `ATX_REQ_CTRL_SET : `ATX_RSP_CTRL_SET);
        assign clrHit = regWr && wa == (c == 0 ? `ATX_REQ_CTRL_CLR : `ATX_RSP_CTRL_CLR);
        assign busyHere = (state_reg != async_tx_pkg::ST_IDLE || statusValid) && ctx_reg == c;
        always_ff @(posedge mclk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                ctrl_reg[c] <= 16'h0;
            end
            else
            begin
                if (setHit)
                begin
                    ctrl_reg[c][`ATX_CC_RUN] <= ctrl_reg[c][`ATX_CC_RUN] | regWdata[`ATX_CC_RUN];
                    ctrl_reg[c][`ATX_CC_WAKE] <= ctrl_reg[c][`ATX_CC_WAKE] | regWdata[`ATX_CC_WAKE];
                end
                else if (clrHit)
                begin
                    ctrl_reg[c][`ATX_CC_RUN] <= ctrl_reg[c][`ATX_CC_RUN] & ~regWdata[`ATX_CC_RUN];
                end
                else if (take && desc.ctx == c)
                begin
                    ctrl_reg[c][`ATX_CC_WAKE] <= 1'b0;
                end
                // active follows run while not flushing, but drops only once this context is quiet
                if (ctrl_reg[c][`ATX_CC_RUN] && !flushing)
                begin
                    ctrl_reg[c][`ATX_CC_ACTIVE] <= 1'b1;
                end
                else if (!busyHere && !(take && desc.ctx == c))
                begin
                    ctrl_reg[c][`ATX_CC_ACTIVE] <= 1'b0;
                end
                if (doneNow && doneCtx == c)
                begin
                    ctrl_reg[c][`ATX_CC_EVT_HI:`ATX_CC_EVT_LO] <= doneCode;
                    ctrl_reg[c][`ATX_CC_SPD_HI:`ATX_CC_SPD_LO] <=
                        hdr_reg[`ATX_H0_SPD_HI+96:`ATX_H0_SPD_LO+96];
                end
            end
        end
    end

    // interrupt events; hardware set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            interrupt_event_reg_reg <= 3'b000;
        end
        else
        begin
            for (int b = 0; b < 3; b++)
            begin
                if (regWr && wa == `ATX_INT_EVENT_CLR && regWdata[b])
                begin
                    interrupt_event_reg_reg[b] <= 1'b0;
                end
                if (regWr && wa == `ATX_INT_EVENT_SET && regWdata[b])
                begin
                    interrupt_event_reg_reg[b] <= 1'b1;
                end
            end
            if (busResetIn)
            begin
                interrupt_event_reg_reg[`ATX_IE_BUS_RESET] <= 1'b1;
            end
            if (doneNow && (doneIrq == `ATX_IRQ_ALWAYS || (doneIrq == `ATX_IRQ_ON_ERR &&
                doneCode != `ATX_ACK_COMPLETE && doneCode != `ATX_ACK_PENDING)))
            begin
                interrupt_event_reg_reg[doneCtx ? `ATX_IE_RSP_SENT : `ATX_IE_REQ_SENT] <= 1'b1;
            end
        end
    end

    // node id and retry configuration
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nodeId_reg <= {`ATX_LOCAL_BUS, `ATX_NODE_UNSET};
            retryCfg_reg <= 4'h0;
        end
        else
        begin
            if (regWr && wa == `ATX_NODE_ID)
            begin
                nodeId_reg <= regWdata[15:0];
            end
            if (regWr && wa == `ATX_RETRY_CFG)
            begin
                retryCfg_reg <= regWdata[3:0];
            end
        end
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            regRdata <= 32'h0;
        end
        else if (!regRd)
        begin
            regRdata <= 32'h0;
        end
        else
        begin
            case (wa)
                `ATX_REQ_CTRL_SET, `ATX_REQ_CTRL_CLR: regRdata <= {16'h0, ctrl_reg[0]};
                `ATX_RSP_CTRL_SET, `ATX_RSP_CTRL_CLR: regRdata <= {16'h0, ctrl_reg[1]};
                `ATX_INT_EVENT_SET, `ATX_INT_EVENT_CLR: regRdata <= {29'h0, interrupt_event_reg_reg};
                `ATX_NODE_ID: regRdata <= {16'h0, nodeId_reg};
                `ATX_RETRY_CFG: regRdata <= {28'h0, retryCfg_reg};
                default: regRdata <= 32'h0;
            endcase
        end
    end

    // checks
    sequence s_reset_in_ack;
        state_reg == async_tx_pkg::ST_ACK && flushing;
    endsequence

    sequence s_status_missing;
        statusValid && statusData[4:0] == `ATX_EVT_MISSING_ACK;
    endsequence

    status_active_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(statusValid) |-> statusData[10])
        else $error("status written without active");
    missing_ack_a: assert property (@(posedge mclk) disable iff (!arst_n)
        s_reset_in_ack |=> s_status_missing)
        else $error("reset during ack wait not missing-ack");
    no_send_a: assert property (@(posedge mclk) disable iff (!arst_n)
        flushing |=> !pkt.valid)
        else $error("packet sent during bus reset");
    active_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (statusValid && statusCtx == 1'b0) |=> ctrl_reg[0][10] || !$past(ctrl_reg[0][10]))
        else $error("request active dropped with status pending");
    first_quad_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (pkt.valid && qIdx_reg == 2'd0) |-> pkt.data[31:16] == hdr_reg[95:80])
        else $error("destination not in first quadlet");
    src_bus_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (pkt.valid && pkt.data[31:22] != `ATX_LOCAL_BUS && qIdx_reg == 2'd1) |->
        hdr_reg[`ATX_H0_SRCBUS+96])
        else $error("bus number used while select clear");
    irq_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (doneNow && doneIrq == `ATX_IRQ_ALWAYS && !doneCtx) |=> interrupt_event_reg_reg[0])
        else $error("request sent event missing");
    retry_limit_a: assert property (@(posedge mclk) disable iff (!arst_n)
        retryNow |-> retryCnt_reg < retryCfg_reg ##1 state_reg == async_tx_pkg::ST_SEND)
        else $error("retry beyond configured limit");
    flush_drop_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (take && flushing) |=> statusValid && statusData[4:0] == `ATX_EVT_FLUSHED)
        else $error("descriptor not discarded while flushing");

endmodule : async_transmit_context

// ---- atx_link_model.sv ----
`timescale 1ns/1ps
module atx_link_model (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // engine link side
    input wire async_tx_pkg::pkt_s pkt,
    output logic pktReady,
    output async_tx_pkg::ack_s ack,
    // bench control, ack code 0 keeps the far node silent
    input wire logic slow,
    input wire logic [4:0] ackCode,
    // last packet seen
    output logic [3:0][31:0] quads,
    output logic [2:0] quadCount,
    output logic [2:0] lastSpeed
);
    logic [3:0] lag;
    logic fresh;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pktReady <= 1'b0;
            ack <= '0;
            quads <= '0;
            quadCount <= 3'h0;
            lastSpeed <= 3'h0;
            lag <= 4'h0;
            fresh <= 1'b1;
        end
        else
        begin
            // slow mode stalls every other cycle
            pktReady <= slow ? ~pktReady : 1'b1;
            ack.valid <= 1'b0;
            // idle ack lines invert the last code every cycle
            ack.code <= ~ack.code;
            if (pkt.valid && pktReady)
            begin
                if (fresh)
                begin
                    quads <= {96'h0, pkt.data};
                    quadCount <= 3'h1;
                end
                else
                begin
                    quads[quadCount[1:0]] <= pkt.data;
                    quadCount <= quadCount + 3'h1;
                end
                fresh <= pkt.last;
                lastSpeed <= pkt.speed;
                lag <= pkt.last ? (slow ? 4'h6 : 4'h2) : 4'h0;
            end
            else if (lag != 4'h0)
            begin
                lag <= lag - 4'h1;
                if (lag == 4'h1 && ackCode != 5'h00)
                begin
                    ack.valid <= 1'b1;
                    ack.code <= ackCode;
                end
            end
        end
    end
endmodule : atx_link_model

// ---- async_transmit_context_tb_top.sv ----
`timescale 1ns/1ps
`include "async_tx_defs.svh"
module async_transmit_context_tb_top;
    localparam logic [9:0] BUS = 10'h155;
    localparam logic [31:0] Q1 = 32'h0042_FFFF;
    localparam logic [31:0] Q2 = 32'h1230_0004;
    localparam logic [31:0] Q3 = 32'hCAFE_0010;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    async_tx_pkg::desc_s desc = '0;
    logic descReady;
    logic statusValid;
    logic statusCtx;
    logic [15:0] statusData;
    logic statusDone = 1'b0;
    async_tx_pkg::pkt_s pkt;
    logic pktReady;
    async_tx_pkg::ack_s ack;
    logic busResetIn = 1'b0;
    logic slow = 1'b0;
    logic [4:0] ackCode = 5'h00;
    logic [3:0][31:0] quads;
    logic [2:0] quadCount;
    logic [2:0] lastSpeed;
    logic sawPkt = 1'b0;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;

    always #2.5 mclk = ~mclk;

    async_transmit_context dut (.mclk, .arst_n, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .desc, .descReady, .statusValid, .statusCtx, .statusData, .statusDone,
        .pkt, .pktReady, .ack, .busResetIn);

    atx_link_model link (.mclk, .arst_n, .pkt, .pktReady, .ack, .slow, .ackCode, .quads,
        .quadCount, .lastSpeed);

    task automatic results;
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    // ceiling well above the several hundred cycles the run needs
    always @(posedge mclk)
    begin
        cyc++;
        if (pkt.valid)
            sawPkt <= 1'b1;
        if (cyc == 20000)
        begin
            fails++;
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask : rd

    function automatic logic [31:0] mkq0(input logic sel, input logic [2:0] spd,
                                         input logic [3:0] tc);
        return {8'h00, sel, 4'h0, spd, 6'h2A, `ATX_RT_X, tc, 4'h5};
    endfunction : mkq0

    task automatic post(input logic ctx, input logic [1:0] ic, input logic [31:0] q0,
                        input logic [31:0] q1, input logic [31:0] q2, input logic [31:0] q3,
                        output logic [15:0] st);
        int n;
        @(posedge mclk);
        desc <= {1'b1, ctx, ic, q0, q1, q2, q3};
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (!descReady && n < 100);
        desc <= '0;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end while (!statusValid && n < 200);
        st = statusData;
        chk("statusCtx", ctx, statusCtx);
        @(posedge mclk);
        statusDone <= 1'b1;
        @(posedge mclk);
        statusDone <= 1'b0;
    endtask : post

    task automatic stat(input logic [15:0] st, input logic rb, input logic [4:0] ec);
        chk("status", {rb, 1'b1, ec}, {st[15], st[10], st[4:0]});
    endtask : stat

    task automatic t_regs;
        logic [31:0] r;
        rd(`ATX_NODE_ID, r);
        chk("nodeIdReset", 32'h0000_FFFF, r);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, r);
        chk("unmapped", 32'h0000_0000, r);
        wr(`ATX_NODE_ID, {16'h0000, BUS, 6'h05});
        wr(`ATX_REQ_CTRL_SET, 32'h0000_8000);
        wr(`ATX_RSP_CTRL_SET, 32'h0000_8000);
        rd(`ATX_RSP_CTRL_CLR, r);
        chk("ctrlViaClr", 1'b1, r[15]);
        wr(`ATX_RSP_CTRL_CLR, 32'h0000_8000);
        rd(`ATX_RSP_CTRL_SET, r);
        chk("ctrlCleared", 1'b0, r[15]);
        wr(`ATX_RSP_CTRL_SET, 32'h0000_8000);
    endtask : t_regs

    task automatic xfer(input logic ctx, input logic [1:0] ic, input logic [3:0] tc,
                        input logic sel, input logic [2:0] spd, input logic [4:0] ak);
        logic [31:0] q0;
        logic [31:0] r;
        logic [15:0] st;
        logic three;
        logic irq;
        q0 = mkq0(sel, spd, tc);
        three = (tc == 4'h4) || (tc == 4'h2);
        irq = (ic == 2'h3) || (ic == 2'h1 && ak != 5'h11 && ak != 5'h12);
        ackCode <= ak;
        post(ctx, ic, q0, Q1, Q2, Q3, st);
        stat(st, 1'b1, ak);
        chk("hdr0", {Q1[31:16], q0[15:10], `ATX_RT_1, q0[7:0]}, quads[0]);
        chk("hdr1", {sel ? BUS : 10'h3FF, 6'h05, Q1[15:0]}, quads[1]);
        chk("hdr2", Q2, quads[2]);
        chk("hdr3", three ? 32'h0000_0000 : Q3, quads[3]);
        chk("quadCount", three ? 32'h3 : 32'h4, quadCount);
        chk("speed", spd, lastSpeed);
        rd(ctx ? `ATX_RSP_CTRL_SET : `ATX_REQ_CTRL_SET, r);
        chk("eventCode", ak, r[4:0]);
        rd(`ATX_INT_EVENT_SET, r);
        chk("sentIrq", irq, r[ctx]);
        wr(`ATX_INT_EVENT_CLR, 32'h0000_0003);
    endtask : xfer

    task automatic t_formats;
        logic [3:0] tcs [6] = '{4'h1, 4'h4, 4'h2, 4'h5, 4'hA, 4'h1};
        logic [1:0] ics [6] = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h1, 2'h3};
        logic [4:0] aks [6] = '{5'h11, 5'h14, 5'h16, 5'h12, 5'h11, 5'h15};
        wr(`ATX_RETRY_CFG, 32'h0000_0000);
        for (int i = 0; i < 6; i++)
        begin
            slow <= i[0];
            xfer(tcs[i] == 4'h2, ics[i], tcs[i], i[0], 3'(i % 3), aks[i]);
        end
    endtask : t_formats

    task automatic t_retry(input logic [4:0] a1, input logic [4:0] a2, input logic [1:0] rt);
        logic [15:0] st;
        int n;
        wr(`ATX_RETRY_CFG, 32'h0000_0001);
        ackCode <= a1;
        fork
            post(1'b0, 2'h0, mkq0(1'b0, 3'h2, 4'h1), Q1, Q2, Q3, st);
            begin
                n = 0;
                do
                begin
                    @(posedge mclk);
                    n++;
                end while (!ack.valid && n < 200);
                ackCode <= a2;
            end
        join
        stat(st, 1'b1, a2);
        chk("retryCode", rt, quads[0][9:8]);
    endtask : t_retry

    // mid: reset while the packet is half sent, else after it but before its ack
    task automatic t_reset(input logic mid, input logic [4:0] ec);
        logic [31:0] r;
        logic [15:0] st;
        int n;
        slow <= mid;
        ackCode <= mid ? 5'h11 : 5'h00;
        fork
            post(1'b0, 2'h3, mkq0(1'b0, 3'h0, 4'h1), Q1, Q2, Q3, st);
            begin
                n = 0;
                do
                begin
                    @(posedge mclk);
                    n++;
                end while (!(pkt.valid && pktReady && (mid || pkt.last)) && n < 200);
                busResetIn <= 1'b1;
                repeat (6)
                begin
                    @(posedge mclk);
                    busResetIn <= 1'b0;
                    #1;
                    chk("txHalt", 1'b0, pkt.valid);
                end
            end
        join
        stat(st, 1'b1, ec);
        rd(`ATX_INT_EVENT_SET, r);
        chk("resetEvent", 1'b1, r[2]);
        wr(`ATX_REQ_CTRL_CLR, 32'h0000_8000);
        wr(`ATX_RSP_CTRL_CLR, 32'h0000_8000);
        rd(`ATX_REQ_CTRL_SET, r);
        chk("active", 1'b0, r[10]);
        sawPkt = 1'b0;
        post(1'b1, 2'h0, mkq0(1'b0, 3'h0, 4'h2), Q1, Q2, Q3, st);
        stat(st, 1'b0, `ATX_EVT_FLUSHED);
        chk("flushNoTx", 1'b0, sawPkt);
        wr(`ATX_INT_EVENT_CLR, 32'h0000_0004);
        wr(`ATX_REQ_CTRL_SET, 32'h0000_8000);
        wr(`ATX_RSP_CTRL_SET, 32'h0000_8000);
    endtask : t_reset

    initial
    begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        t_regs();
        t_formats();
        t_retry(`ATX_ACK_BUSY_A, `ATX_ACK_COMPLETE, `ATX_RT_A);
        t_retry(`ATX_ACK_BUSY_B, `ATX_ACK_BUSY_B, `ATX_RT_B);
        t_reset(1'b1, `ATX_EVT_FLUSHED);
        t_reset(1'b0, `ATX_EVT_MISSING_ACK);
        xfer(1'b1, 2'h3, 4'h2, 1'b1, 3'h1, `ATX_ACK_COMPLETE);
        results();
    end
endmodule : async_transmit_context_tb_top
